/* verilog/smp_pkg.sv */
// Shared constants for the byte-wide serial master port.
// Assumes a single 20 MHz system clock.
package smp_pkg;

    // System clock figures
    localparam int CLK_MHZ = 20;                  // System clock rate
    localparam int US_CYCLES = CLK_MHZ;           // Cycles per microsecond

    // Transaction shape
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;  // SCK pulses per byte
    localparam logic [2:0] LAST_BIT_IDX  = 3'h7;  // Index of final bit

    // Divider select codes: divide by 2 << code
    localparam logic [2:0] DIV_SEL_2   = 3'h0;
    localparam logic [2:0] DIV_SEL_128 = 3'h6;    // Largest divider
    localparam logic [6:0] HALF_ONE    = 7'h01;   // Half period at div 2

    // Option flag positions, zero word selects all defaults
    localparam int OPT_SCK_IDLE_HIGH = 0;         // SCK idles high
    localparam int OPT_LSB_FIRST     = 1;         // Shift LSB first
    localparam int OPT_EDGE_TRAILING = 2;         // Sample on trailing edge
    localparam logic [2:0] OPT_DEFAULTS = 3'h0;   // All defaults

    // FIFO shape
    localparam int FIFO_WIDTH = 17;               // Data, delay, delay flag
    localparam int FIFO_DEPTH = 16;               // Words of request buffer

    // Master state machine
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LEAD  = 2'b01,
        ST_TRAIL = 2'b10,
        ST_WAIT  = 2'b11
    } smp_state_t;

endpackage : smp_pkg

/* verilog/smp_fifo.sv */
// Request FIFO, width and depth by parameter, valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module smp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];       // Storage words
    logic [AW-1:0]    wr_q, wr_d;          // Write pointer
    logic [AW-1:0]    rd_q, rd_d;          // Read pointer
    logic [AW:0]      cnt_q, cnt_d;        // Words held
    logic             rdy_q, rdy_d;        // Room for another word
    logic             push, pop;           // Handshakes this cycle

    // Ready registered so the port comes straight from a flip-flop
    assign in_ready  = rdy_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update
    always_comb begin
        wr_d  = push ? wr_q + 1'b1 : wr_q;
        rd_d  = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        rdy_d = (cnt_d < (AW+1)'(DEPTH));
    end

    // Register pointers; storage written without reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

    // Word storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule : smp_fifo

/* verilog/smp_wait.sv */
// Post-transfer wait timer counting whole microseconds.
// Assumes start arrives as a single-cycle pulse while the timer is idle.
`timescale 1ns/1ps
module smp_wait
    import smp_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Control
    input  wire logic       start,
    input  wire logic [7:0] wait_us,
    output logic            busy
);
    logic [7:0] us_q, us_d;            // Microseconds left
    logic [4:0] tick_q, tick_d;        // Cycles within a microsecond
    logic       run_q, run_d;          // Timer active

    assign busy = run_q;

    // Count down microseconds, zero wait ends at once
    always_comb begin
        us_d   = us_q;
        tick_d = tick_q;
        run_d  = run_q;
        if (start) begin
            us_d   = wait_us;
            tick_d = 5'(US_CYCLES - 1);
            run_d  = (wait_us != 8'h00);
        end else if (run_q) begin
            if (tick_q == 5'h00) begin
                tick_d = 5'(US_CYCLES - 1);
                us_d   = us_q - 8'h01;
                run_d  = (us_q != 8'h01);
            end else begin
                tick_d = tick_q - 5'h01;
            end
        end
    end

    // State registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            us_q   <= 8'h00;
            tick_q <= 5'h00;
            run_q  <= 1'b0;
        end else begin
            us_q   <= us_d;
            tick_q <= tick_d;
            run_q  <= run_d;
        end
    end
endmodule : smp_wait

/* verilog/smp_master.sv */
// Byte-wide serial master: one byte out and one byte in per transaction.
// Assumes synchronous inputs, one 20 MHz clock, slave honours select.
`timescale 1ns/1ps

module smp_master
    import smp_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Configuration
    input  wire logic [2:0] div_sel,
    input  wire logic [2:0] options,
    input  wire logic       init,
    input  wire logic       ss_is_output,
    // Request stream
    input  wire logic       req_valid,
    output logic            req_ready,
    input  wire logic [7:0] req_data,
    input  wire logic       req_delay,
    input  wire logic [7:0] after_transfer_wait,
    // Answer
    output logic            busy,
    output logic            done,
    output logic [7:0]      rx_data,
    output logic            master_enable_bit,
    // Serial pins
    output logic            sck,
    output logic            sck_oe,
    output logic            mosi,
    output logic            mosi_oe,
    output logic            miso_oe,
    input  wire logic       miso_in,
    input  wire logic       ss_n_in,
    output logic            ss_pullup_en
);
    // Request FIFO outputs
    logic        f_valid;                // Request waiting
    logic        f_ready;                // Master takes request
    logic [16:0] f_data;                 // Data, wait, delay flag

    // Master state
    smp_state_t  st_q, st_d;             // Sequencer
    logic [6:0]  half_q, half_d;         // Half period counter
    logic [6:0]  half_len_q, half_len_d; // Latched half period
    logic [2:0]  bit_q, bit_d;           // Bits done
    logic [7:0]  tx_q, tx_d;             // Outgoing shift
    logic [7:0]  rx_q, rx_d;             // Incoming shift
    logic [2:0]  opt_q, opt_d;           // Latched options
    logic        men_q, men_d;           // Master enable bit
    logic        sck_q, sck_d;           // SCK level
    logic        mosi_q, mosi_d;         // MOSI level
    logic        busy_q, busy_d;         // Busy output
    logic        done_q, done_d;         // Done pulse
    logic [7:0]  rxo_q, rxo_d;           // Returned byte
    logic        oe_q, oe_d;             // Pin drive enables
    logic        pu_q, pu_d;             // Select pull-up
    logic        wait_start;             // Kick post-transfer wait
    logic        wait_busy;              // Post-transfer wait running
    logic        dly_q, dly_d;           // Current request has wait
    logic [7:0]  dly_us_q, dly_us_d;     // Wait length
    logic        idle_lvl;               // SCK idle level
    logic        half_end;               // Half period expires
    logic        lsb;                    // LSB first selected
    logic        trail;                  // Sample on trailing edge
    logic [7:0]  tx_rev;                 // Data in shift order
    logic        wait_start_q;           // Wait kicked last cycle

    // Request buffer; back-pressure reaches req_ready
    smp_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (req_valid),
        .in_ready  (req_ready),
        .in_data   ({req_delay, after_transfer_wait, req_data}),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    // Post-transfer wait timer
    smp_wait u_wait (
        .clk     (clk),
        .arst_n  (arst_n),
        .start   (wait_start),
        .wait_us (dly_us_q),
        .busy    (wait_busy)
    );

    // Option decode; zero word leaves all defaults
    assign idle_lvl = opt_q[OPT_SCK_IDLE_HIGH];
    assign lsb      = opt_q[OPT_LSB_FIRST];
    assign trail    = opt_q[OPT_EDGE_TRAILING];
    assign half_end = (half_q == 7'h00);

    // Pop the FIFO only when idle so requests never overlap
    assign f_ready = (st_q == ST_IDLE);

    // Reorder so bit 7 sits at bit 0 and shifts first when MSB first
    // Lets one right shifter serve both bit orders
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            tx_rev[i] = f_data[7-i];
        end
    end

    // Sequencer next state
    always_comb begin
        st_d       = st_q;
        half_d     = half_q;
        half_len_d = half_len_q;
        bit_d      = bit_q;
        tx_d       = tx_q;
        rx_d       = rx_q;
        opt_d      = opt_q;
        men_d      = men_q;
        sck_d      = sck_q;
        mosi_d     = mosi_q;
        busy_d     = busy_q;
        done_d     = 1'b0;
        rxo_d      = rxo_q;
        oe_d       = oe_q;
        pu_d       = pu_q;
        dly_d      = dly_q;
        dly_us_d   = dly_us_q;
        wait_start = 1'b0;

        // Initialisation latches configuration and pin directions
        if (init && st_q == ST_IDLE) begin
            men_d  = 1'b1;
            oe_d   = 1'b1;
            pu_d   = !ss_is_output;
            opt_d  = options;
            sck_d  = options[OPT_SCK_IDLE_HIGH];
            // Half period is divider/2 cycles; div code 7 clamps
            half_len_d = (div_sel > DIV_SEL_128) ?
                         (HALF_ONE << DIV_SEL_128) :
                         (HALF_ONE << div_sel);
        end

        case (st_q)
            ST_IDLE: begin
                sck_d = (init && st_q == ST_IDLE) ?
                        options[OPT_SCK_IDLE_HIGH] : idle_lvl;
                if (f_valid) begin
                    busy_d   = 1'b1;
                    dly_d    = f_data[16];
                    dly_us_d = f_data[15:8];
                    bit_d    = 3'h0;
                    half_d   = half_len_q - 7'h01;
                    rx_d     = 8'h00;
                    if (men_q) begin
                        // First bit set up before leading edge
                        tx_d   = lsb ? f_data[7:0] : tx_rev;
                        mosi_d = lsb ? f_data[0] : f_data[7];
                        st_d   = ST_LEAD;
                    end else begin
                        // Out of master mode: answer zero at once
                        rxo_d  = 8'h00;
                        busy_d = 1'b0;
                        done_d = 1'b1;
                    end
                end
            end
            ST_LEAD: begin
                // Leading edge after a full half period
                if (half_end) begin
                    sck_d  = !idle_lvl;
                    half_d = half_len_q - 7'h01;
                    if (!trail) begin
                        rx_d = {rx_q[6:0], miso_in};
                    end
                    st_d = ST_TRAIL;
                end else begin
                    half_d = half_q - 7'h01;
                end
            end
            ST_TRAIL: begin
                // Trailing edge returns SCK to idle, sets next bit
                if (half_end) begin
                    sck_d  = idle_lvl;
                    half_d = half_len_q - 7'h01;
                    if (trail) begin
                        rx_d = {rx_q[6:0], miso_in};
                    end
                    if (bit_q == LAST_BIT_IDX) begin
                        st_d = ST_WAIT;
                        wait_start = dly_q;
                    end else begin
                        bit_d  = bit_q + 3'h1;
                        tx_d   = {1'b0, tx_q[7:1]};
                        mosi_d = tx_q[1];        // Next bit out
                        st_d   = ST_LEAD;
                    end
                end else begin
                    half_d = half_q - 7'h01;
                end
            end
            ST_WAIT: begin
                // Hold busy through the optional wait
                if (!wait_busy && !wait_start_q) begin
                    for (int i = 0; i < 8; i++) begin
                        rxo_d[i] = lsb ? rx_q[7-i] : rx_q[i];
                    end
                    busy_d = 1'b0;
                    done_d = 1'b1;
                    st_d   = ST_IDLE;
                end
            end
            default: begin
                // Unused codes fall back to idle
                st_d = ST_IDLE;
            end
        endcase

        // Mode fault wins over all: low select input drops master mode
        if (!ss_is_output && !ss_n_in) begin
            men_d = 1'b0;
        end
    end

    // One-cycle gap after the wait kick; the timer's busy is already set in the
    // first wait state cycle, so the gap only holds a delayed request with a
    // zero wait one cycle longer than a request without delay
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_start_q <= 1'b0;
        end else begin
            wait_start_q <= wait_start;
        end
    end

    // Sequencer registers
    // Reset leaves the pins undriven until init
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q       <= ST_IDLE;
            half_q     <= 7'h00;
            half_len_q <= HALF_ONE;
            bit_q      <= 3'h0;
            tx_q       <= 8'h00;
            rx_q       <= 8'h00;
            opt_q      <= OPT_DEFAULTS;
            men_q      <= 1'b0;
            sck_q      <= 1'b0;
            mosi_q     <= 1'b0;
            busy_q     <= 1'b0;
            done_q     <= 1'b0;
            rxo_q      <= 8'h00;
            oe_q       <= 1'b0;
            pu_q       <= 1'b0;
            dly_q      <= 1'b0;
            dly_us_q   <= 8'h00;
        end else begin
            st_q       <= st_d;
            half_q     <= half_d;
            half_len_q <= half_len_d;
            bit_q      <= bit_d;
            tx_q       <= tx_d;
            rx_q       <= rx_d;
            opt_q      <= opt_d;
            men_q      <= men_d;
            sck_q      <= sck_d;
            mosi_q     <= mosi_d;
            busy_q     <= busy_d;
            done_q     <= done_d;
            rxo_q      <= rxo_d;
            oe_q       <= oe_d;
            pu_q       <= pu_d;
            dly_q      <= dly_d;
            dly_us_q   <= dly_us_d;
        end
    end

    // Outputs straight from flip-flops, except miso_oe tied low
    assign busy              = busy_q;
    assign done              = done_q;
    assign rx_data           = rxo_q;
    assign master_enable_bit = men_q;
    assign sck               = sck_q;
    assign sck_oe            = oe_q;
    assign mosi              = mosi_q;
    assign mosi_oe           = oe_q;
    assign miso_oe           = 1'b0;     // MISO never driven here
    assign ss_pullup_en      = pu_q;
endmodule : smp_master

/* tb/smp_slave_model.sv */
// Behavioural slave peripheral for the far side of the serial master.
// Assumes the bench hands it the SCK idle level and the bit order.
`timescale 1ns/1ps
module smp_slave_model (
    // Serial pins
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    output logic            miso,
    // Setup and capture
    input  wire logic       cpol,
    input  wire logic       lsb,
    input  wire logic [7:0] tx_byte,
    output logic [7:0]      rx_byte
);
    logic [2:0] idx_q = 3'h0;   // Bit position within the byte
    logic       last_q = 1'b0;  // Last level driven on MISO
    logic       sck_p = 1'b0;   // SCK level seen last time
    logic       bit_w;          // Bit due on MISO now

    assign bit_w = tx_byte[lsb ? idx_q : 3'h7 - idx_q];
    // Released line shows the inverse, never a held value
    assign miso = sel_n ? ~last_q : bit_w;

    // Remember what was last driven
    always @(bit_w or sel_n) begin
        if (!sel_n) last_q = bit_w;
    end

    // Capture on leading edge, next bit after trailing edge
    always @(sck or sel_n) begin
        if (sel_n) begin
            idx_q <= 3'h0;
        end else if (sck != sck_p && sck != cpol) begin
            rx_byte <= lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
        end else if (sck != sck_p) begin
            idx_q <= idx_q + 3'h1;
        end
        sck_p = sck;
    end
endmodule : smp_slave_model

/* tb/smp_master_props.sv */
// Concurrent checks on the serial master's ports.
// Assumes init is only raised while the master is idle.
`timescale 1ns/1ps
module smp_master_props
    import smp_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       arst_n,
    // Configuration and requests
    input wire logic [2:0] div_sel,
    input wire logic [2:0] options,
    input wire logic       init,
    input wire logic       ss_is_output,
    input wire logic       req_ready,
    // Answer and pins
    input wire logic       busy,
    input wire logic       done,
    input wire logic [7:0] rx_data,
    input wire logic       master_enable_bit,
    input wire logic       sck,
    input wire logic       sck_oe,
    input wire logic       mosi_oe,
    input wire logic       miso_oe,
    input wire logic       ss_n_in,
    input wire logic       ss_pullup_en
);
    logic       cpol_q, cpol_d;   // Latched idle level
    logic [6:0] half_q, half_d;   // Expected half period
    logic [7:0] cnt_q, cnt_d;     // Cycles since SCK moved
    logic [3:0] lead_q, lead_d;   // Leading edges this byte
    logic       run_q, run_d;     // A toggle already seen
    logic       sck_p_q;          // SCK one cycle ago
    logic       tog;              // SCK moved this cycle

    assign tog = sck != sck_p_q;

    // Shadow configuration and edge counters
    always_comb begin
        cpol_d = cpol_q;
        half_d = half_q;
        if (init && !busy) begin
            cpol_d = options[OPT_SCK_IDLE_HIGH];
            half_d = (div_sel > DIV_SEL_128) ? 7'h40 : HALF_ONE << div_sel;
        end
        cnt_d  = tog ? 8'h01 : cnt_q + 8'h01;
        lead_d = done ? 4'h0 : lead_q + {3'h0, tog && (sck != cpol_q)};
        run_d  = busy && (run_q || tog);
    end

    // Register the shadow state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cpol_q  <= 1'b0;
            half_q  <= HALF_ONE;
            cnt_q   <= 8'h00;
            lead_q  <= 4'h0;
            run_q   <= 1'b0;
            sck_p_q <= 1'b0;
        end else begin
            cpol_q  <= cpol_d;
            half_q  <= half_d;
            cnt_q   <= cnt_d;
            lead_q  <= lead_d;
            run_q   <= run_d;
            sck_p_q <= sck;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_done_single: assert property (done |=> !done)
        else $error("done held for more than one cycle");
    a_busy_ends_done: assert property ($fell(busy) |-> done)
        else $error("busy fell without done");
    a_sck_idle_lvl: assert property (sck_oe && !busy |-> sck == cpol_q)
        else $error("SCK away from idle level between bytes");
    a_pins_enabled: assert property (master_enable_bit |->
        sck_oe && mosi_oe && !miso_oe)
        else $error("pin directions wrong in master mode");
    a_pullup_init: assert property ($rose(sck_oe) |->
        ss_pullup_en == !$past(ss_is_output))
        else $error("select pull-up wrong after init");
    a_fault_drops: assert property (master_enable_bit && !ss_is_output
        && !ss_n_in && !init |=> !master_enable_bit)
        else $error("low select did not drop master mode");
    a_off_zero: assert property (done && !master_enable_bit |->
        rx_data == 8'h00)
        else $error("non-zero byte returned outside master mode");
    a_eight_leads: assert property (done |-> lead_q ==
        (master_enable_bit ? BITS_PER_BYTE : 4'h0))
        else $error("wrong count of SCK pulses");
    a_sck_half: assert property (busy && tog && run_q |->
        cnt_q == {1'b0, half_q})
        else $error("SCK half period wrong");

    // Main scenarios reached
    c_master_byte: cover property (done && master_enable_bit);
    c_off_byte: cover property (done && !master_enable_bit);
    c_fifo_full: cover property (busy && !req_ready);
endmodule : smp_master_props

bind smp_master smp_master_props u_smp_master_props (
    .clk, .arst_n, .div_sel, .options, .init, .ss_is_output, .req_ready,
    .busy, .done, .rx_data, .master_enable_bit, .sck, .sck_oe, .mosi_oe,
    .miso_oe, .ss_n_in, .ss_pullup_en
);

/* tb/spi_master_port_tb_top.sv */
// Self-checking bench: serial master against a behavioural slave.
// Assumes the request FIFO holds FIFO_DEPTH words.
`timescale 1ns/1ps
module spi_master_port_tb_top
    import smp_pkg::*;
;
    // Stimulus
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    logic [2:0] div_sel = DIV_SEL_2;
    logic [2:0] options = OPT_DEFAULTS;
    logic       init = 1'b0;
    logic       ss_is_output = 1'b1;
    logic       req_valid = 1'b0;
    logic [7:0] req_data = 8'h00;
    logic       req_delay = 1'b0;
    logic [7:0] wait_us = 8'h00;
    logic       sel_n = 1'b1;     // Select line, bench stands in
    logic [7:0] reply = 8'h00;    // Byte the slave returns
    // Observed
    logic       req_ready, busy, done, master_enable_bit, miso;
    logic       sck, sck_oe, mosi, mosi_oe, miso_oe, ss_pullup_en;
    logic [7:0] rx_data, slave_rx;
    int         fails = 0;
    int         compares = 0;

    always #25 clk = ~clk;

    smp_master u_smp_master (
        .clk, .arst_n, .div_sel, .options, .init, .ss_is_output, .req_valid,
        .req_ready, .req_data, .req_delay, .after_transfer_wait(wait_us),
        .busy, .done, .rx_data, .master_enable_bit, .sck, .sck_oe, .mosi,
        .mosi_oe, .miso_oe, .miso_in(miso), .ss_n_in(sel_n), .ss_pullup_en
    );
    smp_slave_model u_smp_slave_model (
        .sck, .mosi, .sel_n, .miso, .cpol(options[OPT_SCK_IDLE_HIGH]),
        .lsb(options[OPT_LSB_FIRST]), .tx_byte(reply), .rx_byte(slave_rx)
    );

    // Verdict and end of run
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize

    task automatic check(input logic ok, input string msg);
        compares++;
        if (!ok) begin
            fails++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : check

    // Bounded wait for the next completion pulse
    task automatic wait_done(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (n > 8000) begin
                check(1'b0, "no completion");
                summarize();
            end
        end while (done !== 1'b1);
    endtask : wait_done

    // One request held until taken, then one answer
    task automatic xfer(input logic [7:0] d, rep, exp_rx, input logic dl,
                        input logic [7:0] w, output int n);
        int k;
        @(posedge clk);
        reply <= rep;
        req_valid <= 1'b1;
        req_data <= d;
        req_delay <= dl;
        wait_us <= w;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (req_ready !== 1'b1 && k < 4000);
        if (k >= 4000) begin
            check(1'b0, "request never taken");
            summarize();
        end
        @(posedge clk);
        req_valid <= 1'b0;
        wait_done(n);
        check(k < 4000 && rx_data === exp_rx, "returned byte");
    endtask : xfer

    // Configure with select released, then check pins
    task automatic do_init(input logic [2:0] dv, op, input logic so);
        @(posedge clk);
        sel_n <= 1'b1;
        div_sel <= dv;
        options <= op;
        ss_is_output <= so;
        init <= 1'b1;
        @(posedge clk);
        init <= 1'b0;
        @(posedge clk);
        sel_n <= !so;
        @(negedge clk);
        check(sck === op[0] && sck_oe === 1'b1 && mosi_oe === 1'b1 &&
              miso_oe === 1'b0, "pins");
        check(ss_pullup_en === !so, "select pull-up");
    endtask : do_init

    // Reset state, then a byte before init answers zero
    task automatic t_reset;
        int n;
        check(master_enable_bit === 1'b0 && sck_oe === 1'b0 &&
              busy === 1'b0 && done === 1'b0, "reset");
        xfer(8'h5A, 8'hC3, 8'h00, 1'b0, 8'h00, n);
    endtask : t_reset

    // Every option word, each on divider code 7 minus the word
    task automatic t_modes;
        int n;
        for (int m = 0; m < 8; m++) begin
            do_init(3'(7 - m), 3'(m), 1'b1);
            xfer(8'hA5 ^ 8'(m), 8'h3C + 8'(m), 8'h3C + 8'(m), 1'b0,
                 8'h00, n);
            check(slave_rx === (8'hA5 ^ 8'(m)), "slave byte");
        end
    endtask : t_modes

    // Post-transfer wait at both ends of its range
    task automatic t_delay;
        int n0;
        int n;
        do_init(DIV_SEL_2, OPT_DEFAULTS, 1'b1);
        xfer(8'h11, 8'h22, 8'h22, 1'b0, 8'h00, n0);
        xfer(8'h33, 8'h44, 8'h44, 1'b1, 8'h00, n);
        check(n >= n0 && n <= n0 + 6, "zero wait");
        xfer(8'h55, 8'h66, 8'h66, 1'b1, 8'hFF, n);
        check(n >= n0 + 5100 && n <= n0 + 5106, "long wait");
    endtask : t_delay

    // Fill the request buffer until refused, then drain in order
    task automatic t_fill;
        int acc;
        int n;
        do_init(DIV_SEL_128, OPT_DEFAULTS, 1'b1);
        @(posedge clk);
        reply <= 8'h96;
        req_delay <= 1'b0;
        req_valid <= 1'b1;
        req_data <= 8'h00;
        acc = 0;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            if (req_ready !== 1'b1) break;
            acc++;
            @(posedge clk);
            req_data <= 8'(acc);
        end
        @(posedge clk);
        req_valid <= 1'b0;
        check(acc == FIFO_DEPTH + 1, "buffer depth");
        for (int i = 0; i < acc; i++) begin
            wait_done(n);
            check(rx_data === 8'h96 && slave_rx === 8'(i), "order");
        end
    endtask : t_fill

    // Select input pulled low knocks out master mode
    task automatic t_fault;
        int n;
        do_init(DIV_SEL_2, OPT_DEFAULTS, 1'b0);
        @(posedge clk);
        sel_n <= 1'b0;
        repeat (2) @(negedge clk);
        check(master_enable_bit === 1'b0, "mode fault");
        @(posedge clk);
        sel_n <= 1'b1;
        xfer(8'h77, 8'hEE, 8'h00, 1'b0, 8'h00, n);
    endtask : t_fault

    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        t_reset();
        t_modes();
        t_delay();
        t_fill();
        t_fault();
        summarize();
    end
endmodule : spi_master_port_tb_top
